/* verilog/tcp_defs.svh */
// constants for the 8-bit timer with compare and pwm output
`ifndef TCP_DEFS_SVH
`define TCP_DEFS_SVH
`define TCP_ADR_CTRL 4'h0
`define TCP_ADR_CNT 4'h1
`define TCP_ADR_CMP 4'h2
`define TCP_ADR_MASK 4'h3
`define TCP_ADR_FLAG 4'h4
`define TCP_ADR_GIE 4'h5
`define TCP_ADR_VACK 4'h6
`define TCP_B_FORCE 7
`define TCP_B_WM_LO 6
`define TCP_B_COM_HI 5
`define TCP_B_COM_LO 4
`define TCP_B_WM_HI 3
`define TCP_B_CMP_EN 1
`define TCP_B_OVF_EN 0
`define TCP_B_CMP_FLG 1
`define TCP_B_OVF_FLG 0
`define TCP_CTRL_RST 8'h00
`define TCP_MASK_RST 8'h00
`define TCP_MAXV 8'hFF
`define TCP_BOTV 8'h00
`define TCP_DIV8 10'h007
`define TCP_DIV64 10'h03F
`define TCP_DIV256 10'h0FF
`define TCP_DIV1024 10'h3FF
`endif

/* verilog/tcp_pkg.sv */
// types for the 8-bit timer with compare and pwm output
package tcp_pkg;
  typedef enum logic [1:0] {
    TCP_WM_NORMAL = 2'h0,
    TCP_WM_PHASE = 2'h1,
    TCP_WM_CLEAR = 2'h2,
    TCP_WM_FAST = 2'h3
  } tcp_wave_t;
  typedef enum logic [1:0] {
    TCP_UP = 2'b01,
    TCP_DOWN = 2'b10
  } tcp_dir_t;
  typedef struct packed {
    logic [3:0] adr;
    logic we;
    logic sel;
    logic [7:0] dat;
  } tcp_req_t;
endpackage

/* verilog/tcp_timer.sv */
// 8-bit timer/counter with one compare unit, pwm output and wishbone registers
//
// Notes on behaviour
// - counter runs on system clock; the timer clock is a one-cycle enable
// - force strobe in non-pwm mode applies compare action to output at once
// - forced compare sets no flag, never clears counter; strobe reads zero
// - mode bits 3 and 6 pick normal, phase pwm, clear-on-match, fast pwm; top
// - compare buffer update point and overflow flag point depend on mode
// - nonzero output mode bits hand the pin over to the compare output
// - non-pwm output modes: disconnect, toggle, clear, set on match
// - fast pwm: 2 clears on match sets at bottom, 3 inverse, 1 reserved
// - phase pwm: 2 clears on up match sets on down match, 3 inverse
// - pwm with compare equal top and upper bit set acts at top instead
// - clock select 0 stops, 1 undivided, 2..5 divide by 8,64,256,1024
// - clock select 6 counts falling, 7 rising edges of external input
// - external edges count even while the pin is an output
// - counter readable and writable; a write blocks the next match
// - compare value checked continuously; match feeds flag and waveform
// - mask holds compare enable at bit 1, overflow enable at bit 0
// - compare flag set on match, cleared by vector ack or writing one
// - interrupt raised when flag, enable and global enable are all set
// - phase pwm counts up to max then down to bottom, max held once
`timescale 1ns/100ps
`include "tcp_defs.svh"
module tcp_timer
  import tcp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_ext_count,
  output logic o_cmp_out,
  output logic o_cmp_pin_own,
  output logic o_cmp_irq,
  output logic o_ovf_irq
);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  tcp_req_t req;
  logic ack_r;
  logic acc;
  logic wr;
  assign req = '{adr: i_wb_adr, we: i_wb_we, sel: i_wb_sel[0], dat: i_wb_dat[7:0]};
  assign acc = i_wb_cyc & i_wb_stb & ~ack_r;
  assign wr = i_wb_cyc & i_wb_stb & ack_r & req.we & req.sel;
  assign o_wb_ack = ack_r;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
    hit = wr & (a == b);
  endfunction

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] cnt_r;
  logic [7:0] cmp_buf_r;
  logic [7:0] cmp_r;
  logic [7:0] mask_r;
  logic gie_r;
  logic cmp_flag_r;
  logic ovf_flag_r;
  logic force_r;
  logic blk_r;
  tcp_wave_t wm;
  logic [1:0] com;
  logic [2:0] csel;
  logic pwm;
  assign wm = tcp_wave_t'({ctrl_r[`TCP_B_WM_HI], ctrl_r[`TCP_B_WM_LO]});
  assign com = {ctrl_r[`TCP_B_COM_HI], ctrl_r[`TCP_B_COM_LO]};
  assign csel = ctrl_r[2:0];
  assign pwm = (wm == TCP_WM_PHASE) | (wm == TCP_WM_FAST);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r <= `TCP_CTRL_RST;
      force_r <= 1'b0;
    end else begin
      force_r <= 1'b0;
      if (hit(req.adr, `TCP_ADR_CTRL)) begin
        ctrl_r <= {1'b0, req.dat[6:0]};
        force_r <= req.dat[`TCP_B_FORCE];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mask_r <= `TCP_MASK_RST;
      gie_r <= 1'b0;
    end else begin
      if (hit(req.adr, `TCP_ADR_MASK)) begin
        mask_r <= req.dat;
      end
      if (hit(req.adr, `TCP_ADR_GIE)) begin
        gie_r <= req.dat[0];
      end
    end
  end

  // ----------------------------------------
  // clock select and prescaler
  // ----------------------------------------
  logic [9:0] pre_r;
  logic [2:0] ext_r;
  logic ext_lvl_r;
  logic tick;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 10'h001;
    end
  end

  // external input sampled regardless of pin direction
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ext_r <= '0;
      ext_lvl_r <= 1'b0;
    end else begin
      ext_r <= {ext_r[1:0], i_ext_count};
      if (ext_r[1] == ext_r[2]) begin
        ext_lvl_r <= ext_r[2];
      end
    end
  end

  logic ext_new;
  assign ext_new = (ext_r[1] == ext_r[2]) ? ext_r[2] : ext_lvl_r;

  always_comb begin
    case (csel)
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = ({7'h00, pre_r[2:0]} == `TCP_DIV8);
      3'h3: tick = ({4'h0, pre_r[5:0]} == `TCP_DIV64);
      3'h4: tick = ({2'h0, pre_r[7:0]} == `TCP_DIV256);
      3'h5: tick = (pre_r == `TCP_DIV1024);
      3'h6: tick = ext_lvl_r & ~ext_new;
      3'h7: tick = ~ext_lvl_r & ext_new;
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  tcp_dir_t dir_r;
  logic [7:0] top;
  logic match;
  logic at_top;
  logic cnt_wr;
  assign top = (wm == TCP_WM_CLEAR) ? cmp_r : `TCP_MAXV;
  assign match = (cnt_r == cmp_r) & tick & ~blk_r;
  assign at_top = (cnt_r == top);
  assign cnt_wr = hit(req.adr, `TCP_ADR_CNT);

  // all counting is gated by the one-cycle tick on i_clk
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= `TCP_BOTV;
      dir_r <= TCP_UP;
    end else if (cnt_wr) begin
      cnt_r <= req.dat;
    end else if (tick) begin
      case (wm)
        TCP_WM_PHASE: begin
          if (dir_r == TCP_UP) begin
            if (cnt_r == `TCP_MAXV) begin
              dir_r <= TCP_DOWN;
              cnt_r <= cnt_r - 8'h01;
            end else begin
              cnt_r <= cnt_r + 8'h01;
            end
          end else begin
            if (cnt_r == `TCP_BOTV) begin
              dir_r <= TCP_UP;
              cnt_r <= cnt_r + 8'h01;
            end else begin
              cnt_r <= cnt_r - 8'h01;
            end
          end
        end
        TCP_WM_CLEAR: begin
          cnt_r <= at_top ? `TCP_BOTV : cnt_r + 8'h01;
          dir_r <= TCP_UP;
        end
        default: begin
          cnt_r <= cnt_r + 8'h01;
          dir_r <= TCP_UP;
        end
      endcase
    end
  end

  // a counter write blocks the match on the next tick
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      blk_r <= 1'b0;
    end else if (cnt_wr) begin
      blk_r <= 1'b1;
    end else if (tick) begin
      blk_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // compare buffer
  // ----------------------------------------
  logic upd;
  always_comb begin
    case (wm)
      TCP_WM_PHASE: upd = tick & (cnt_r == `TCP_MAXV) & (dir_r == TCP_UP);
      TCP_WM_FAST: upd = tick & (cnt_r == `TCP_MAXV);
      default: upd = 1'b1;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cmp_buf_r <= '0;
      cmp_r <= '0;
    end else begin
      if (hit(req.adr, `TCP_ADR_CMP)) begin
        cmp_buf_r <= req.dat;
      end
      if (upd) begin
        cmp_r <= hit(req.adr, `TCP_ADR_CMP) ? req.dat : cmp_buf_r;
      end
    end
  end

  // ----------------------------------------
  // flags
  // ----------------------------------------
  logic ovf_ev;
  logic vack_cmp;
  logic vack_ovf;
  assign ovf_ev = tick & ((wm == TCP_WM_PHASE) ?
    (cnt_r == `TCP_BOTV) & (dir_r == TCP_DOWN) : (cnt_r == `TCP_MAXV));
  assign vack_cmp = hit(req.adr, `TCP_ADR_VACK) & req.dat[`TCP_B_CMP_FLG];
  assign vack_ovf = hit(req.adr, `TCP_ADR_VACK) & req.dat[`TCP_B_OVF_FLG];

  // set wins over clear
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cmp_flag_r <= 1'b0;
      ovf_flag_r <= 1'b0;
    end else begin
      if (match) begin
        cmp_flag_r <= 1'b1;
      end else if (vack_cmp | (hit(req.adr, `TCP_ADR_FLAG) & req.dat[`TCP_B_CMP_FLG])) begin
        cmp_flag_r <= 1'b0;
      end
      if (ovf_ev) begin
        ovf_flag_r <= 1'b1;
      end else if (vack_ovf | (hit(req.adr, `TCP_ADR_FLAG) & req.dat[`TCP_B_OVF_FLG])) begin
        ovf_flag_r <= 1'b0;
      end
    end
  end

  assign o_cmp_irq = gie_r & cmp_flag_r & mask_r[`TCP_B_CMP_EN];
  assign o_ovf_irq = gie_r & ovf_flag_r & mask_r[`TCP_B_OVF_EN];

  // ----------------------------------------
  // waveform output
  // ----------------------------------------
  logic oc_r;
  logic top_case;
  assign top_case = pwm & (cmp_r == `TCP_MAXV) & com[1];

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      oc_r <= 1'b0;
    end else if (!pwm) begin
      if ((match | force_r) & com != 2'h0) begin
        case (com)
          2'h1: oc_r <= ~oc_r;
          2'h2: oc_r <= 1'b0;
          2'h3: oc_r <= 1'b1;
          default: oc_r <= oc_r;
        endcase
      end
    end else if (com[1]) begin
      if (top_case) begin
        if (tick & (cnt_r == `TCP_MAXV)) begin
          oc_r <= ~com[0];
        end
      end else if (wm == TCP_WM_FAST) begin
        if (match) begin
          oc_r <= com[0];
        end else if (tick & (cnt_r == `TCP_MAXV)) begin
          oc_r <= ~com[0];
        end
      end else if (match) begin
        oc_r <= (dir_r == TCP_UP) ? com[0] : ~com[0];
      end
    end
  end

  assign o_cmp_out = oc_r;
  assign o_cmp_pin_own = (com != 2'h0);

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [7:0] rd_nxt;
  logic [31:0] rd_r;
  always_comb begin
    case (req.adr)
      `TCP_ADR_CTRL: rd_nxt = ctrl_r;
      `TCP_ADR_CNT: rd_nxt = cnt_r;
      `TCP_ADR_CMP: rd_nxt = cmp_buf_r;
      `TCP_ADR_MASK: rd_nxt = mask_r;
      `TCP_ADR_FLAG: rd_nxt = {6'h00, cmp_flag_r, ovf_flag_r};
      `TCP_ADR_GIE: rd_nxt = {7'h00, gie_r};
      default: rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_r <= '0;
    end else if (acc) begin
      rd_r <= {24'h0000_00, rd_nxt};
    end
  end
  assign o_wb_dat = rd_r;

endmodule // tcp_timer

/* test/tcp_timer_chk.sv */
// checker on the timer's bus, pin and interrupt ports
`timescale 1ns/100ps
module tcp_timer_chk (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic o_cmp_pin_own,
  input wire logic o_cmp_irq,
  input wire logic o_ovf_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // --
  // shadow of the enables
  // --
  logic tk;
  logic wr0;
  logic gie_r;
  logic [1:0] msk_r;
  assign tk = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr0 = i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_adr == 4'h0;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gie_r <= 1'b0;
      msk_r <= 2'h0;
    end else if (i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we && i_wb_sel[0]) begin
      if (i_wb_adr == 4'h5) gie_r <= i_wb_dat[0];
      if (i_wb_adr == 4'h3) msk_r <= i_wb_dat[1:0];
    end
  end
  a_ack_after_take: assert property (tk |=> o_wb_ack)
    else $error("ack missing");
  a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack too long");
  a_rd_upper_zero: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (o_wb_ack && !i_wb_we && i_wb_adr > 4'h6 |->
    o_wb_dat == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_force_reads_zero: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 4'h0 |->
    !o_wb_dat[7])
    else $error("force strobe read back");
  a_pin_handover: assert property (wr0 |=>
    o_cmp_pin_own == ($past(i_wb_dat[5]) || $past(i_wb_dat[4])))
    else $error("pin ownership wrong");
  a_own_holds: assert property (!wr0 |=> $stable(o_cmp_pin_own))
    else $error("pin ownership moved");
  a_cmp_irq_gated: assert property (!(gie_r && msk_r[1]) |-> !o_cmp_irq)
    else $error("compare irq not gated");
  a_ovf_irq_gated: assert property (!(gie_r && msk_r[0]) |-> !o_ovf_irq)
    else $error("overflow irq not gated");
  c_force: cover property (wr0 && i_wb_dat[7]);
  c_own: cover property (o_cmp_pin_own);
  c_ovf_irq: cover property (o_ovf_irq);
endmodule // tcp_timer_chk
bind tcp_timer tcp_timer_chk tcp_timer_chk_i (
  .i_clk(i_clk),
  .i_rstn(i_rstn),
  .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr),
  .i_wb_sel(i_wb_sel),
  .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack),
  .o_cmp_pin_own(o_cmp_pin_own),
  .o_cmp_irq(o_cmp_irq),
  .o_ovf_irq(o_ovf_irq)
);

/* test/tcp_ext_src.sv */
// model of the board source on the external count input
`timescale 1ns/100ps
module tcp_ext_src (
  input wire logic i_clk,
  output logic o_ext
);
  initial o_ext = 1'b0;
  // three clocks high, three low, idle low between bursts
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (3) @(posedge i_clk);
      o_ext <= 1'b1;
      repeat (3) @(posedge i_clk);
      o_ext <= 1'b0;
    end
  endtask
endmodule // tcp_ext_src

/* test/tb_tcp_timer.sv */
// self-checking bench for the 8-bit timer
`timescale 1ns/100ps
module tb_tcp_timer;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic look = 1'b0;
  logic [31:0] o_wb_dat;
  logic o_wb_ack, ext, pin, own, cirq, oirq;
  logic [7:0] q [$];
  logic [2:0] pq [$];
  logic [7:0] r;
  logic [7:0] fc [4] = '{8'h30, 8'h20, 8'h10, 8'h10};
  logic fe [4] = '{1'h1, 1'h0, 1'h1, 1'h0};
  logic [7:0] pc [2] = '{8'h69, 8'h79};
  logic pe [2] = '{1'h1, 1'h0};
  logic [7:0] ec [2] = '{8'h07, 8'h06};
  int pw [4] = '{61, 125, 509, 2045};
  logic [7:0] pn [4] = '{8'h08, 8'h02, 8'h02, 8'h02};
  int checked = 0;
  int n_fail = 0;
  always #2 i_clk = ~i_clk;
  tcp_timer tcp_timer_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_wb_cyc(stb), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(dat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_ext_count(ext), .o_cmp_out(pin), .o_cmp_pin_own(own),
    .o_cmp_irq(cirq), .o_ovf_irq(oirq));
  tcp_ext_src tcp_ext_src_i (.i_clk(i_clk), .o_ext(ext));
  // --
  // bus and compare tasks
  // --
  task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t read %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_lv(input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t level %b want %b", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    do begin
      @(posedge i_clk);
    end while (o_wb_ack !== 1'b1);
    stb <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    q.push_back(e);
    wb(1'b0, a, 8'h00);
  endtask
  task automatic lv(input logic [1:0] s, input logic e);
    repeat (2) @(posedge i_clk);
    pq.push_back({s, e});
    look <= 1'b1;
    @(posedge i_clk);
    look <= 1'b0;
  endtask
  always @(posedge i_clk) begin
    if (o_wb_ack === 1'b1 && !we) chk_rd(q.pop_front(), o_wb_dat[7:0]);
    if (look) begin
      case (pq[0][2:1])
        2'h0: chk_lv(pq[0][0], pin);
        2'h1: chk_lv(pq[0][0], oirq);
        2'h2: chk_lv(pq[0][0], cirq);
        default: chk_lv(pq[0][0], own);
      endcase
      pq.delete(0);
    end
  end
  initial begin
    void'($urandom(92707));
    repeat (12) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    rd(4'h0, 8'h00);
    rd(4'h3, 8'h00);
    rd(4'h4, 8'h00);
    r = 8'($urandom);
    wr(4'h3, r);
    rd(4'h3, r);
    wr(4'h1, ~r);
    rd(4'h1, ~r);
    wr(4'h2, r);
    wr(4'hF, r);
    rd(4'hF, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, fc[i]);
      wr(4'h0, fc[i] | 8'h80);
      lv(2'h0, fe[i]);
      rd(4'h0, fc[i]);
    end
    rd(4'h4, 8'h00);
    lv(2'h3, 1'b1);
    $display("test force done");
    wr(4'h2, 8'h03);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h09);
    repeat (20) @(posedge i_clk);
    wr(4'h0, 8'h00);
    lv(2'h3, 1'b0);
    rd(4'h4, 8'h02);
    wr(4'h3, 8'h02);
    wr(4'h5, 8'h01);
    lv(2'h2, 1'b1);
    wr(4'h4, 8'h02);
    lv(2'h2, 1'b0);
    rd(4'h4, 8'h00);
    wr(4'h2, 8'h80);
    wr(4'h1, 8'hFE);
    wr(4'h0, 8'h01);
    repeat (4) @(posedge i_clk);
    wr(4'h0, 8'h00);
    rd(4'h4, 8'h01);
    wr(4'h3, 8'h01);
    wr(4'h5, 8'h01);
    lv(2'h1, 1'b1);
    wr(4'h6, 8'h01);
    lv(2'h1, 1'b0);
    $display("test flags done");
    for (int i = 0; i < 2; i++) begin
      wr(4'h1, 8'hFC);
      wr(4'h0, pc[i]);
      repeat (6) @(posedge i_clk);
      wr(4'h0, pc[i] & 8'hF8);
      lv(2'h0, pe[i]);
    end
    $display("test pwm done");
    wr(4'h0, 8'h60);
    wr(4'h2, 8'hFD);
    wr(4'h1, 8'hFB);
    wr(4'h0, 8'h61);
    repeat (6) @(posedge i_clk);
    wr(4'h0, 8'h60);
    lv(2'h0, 1'b1);
    rd(4'h1, 8'hFA);
    $display("test phase done");
    for (int i = 0; i < 4; i++) begin
      wr(4'h1, 8'h00);
      wr(4'h0, 8'(i + 2));
      repeat (pw[i]) @(posedge i_clk);
      wr(4'h0, 8'h00);
      rd(4'h1, pn[i]);
    end
    $display("test prescaler done");
    for (int i = 0; i < 2; i++) begin
      wr(4'h1, 8'h00);
      wr(4'h0, ec[i]);
      tcp_ext_src_i.pulses(5);
      repeat (8) @(posedge i_clk);
      wr(4'h0, 8'h00);
      rd(4'h1, 8'h05);
    end
    $display("test counting done");
    end_of_test;
  end
  initial begin
    #80000;
    n_fail++;
    end_of_test;
  end
endmodule // tb_tcp_timer
